/* verilog/ccss_consts.svh */
/*
 Timing counts, the strap reset value and field positions for the CPU clock
 source select block.
 Assumes a single 25 MHz core clock; included by bare name.
*/
`ifndef CCSS_CONSTS_SVH
`define CCSS_CONSTS_SVH

// Core clock period in ns
`define CCSS_CORE_PERIOD_NS 40
// Free-running PLL period in ns, stand-in for the analog oscillator
`define CCSS_FREERUN_PERIOD_NS 80
// Core cycles per free-running PLL cycle, rounded down, at least one
`define CCSS_FREERUN_CYCLES \
    ((`CCSS_FREERUN_PERIOD_NS / `CCSS_CORE_PERIOD_NS) < 1 ? 1 : \
     (`CCSS_FREERUN_PERIOD_NS / `CCSS_CORE_PERIOD_NS))
// Free-running cycles without a crystal transition before overflow
`define CCSS_WD_OVERFLOW_TICKS 16
// Watchdog disable bit position in the system config register
`define CCSS_SYSCFG_WD_DIS_BIT 4
// Strap reset value when nothing is driven on the pins
`define CCSS_STRAP_DEFAULT 3'h7

`endif

/* verilog/ccss_pkg.sv */
/*
 Types for the CPU clock source select block.
 Assumes ccss_consts.svh carries the numbers.
*/
`default_nettype none

package ccss_pkg;

    // Strap encodings of the clock generation mode
    typedef enum logic [2:0] {
        CCSS_MODE_X2P5 = 3'b000,
        CCSS_MODE_DIV2 = 3'b001,
        CCSS_MODE_X1P5 = 3'b010,
        CCSS_MODE_DIRECT = 3'b011,
        CCSS_MODE_X5 = 3'b100,
        CCSS_MODE_X2 = 3'b101,
        CCSS_MODE_X3 = 3'b110,
        CCSS_MODE_X4 = 3'b111
    } ccss_mode_t;

    // Which source the CPU clock follows
    typedef enum logic [1:0] {
        CCSS_SRC_INPUT = 2'b00,
        CCSS_SRC_ARMING = 2'b01,
        CCSS_SRC_FREERUN = 2'b10
    } ccss_src_t;

endpackage

`default_nettype wire

/* verilog/ccss_sync.sv */
/*
 Two flip-flop synchroniser for pin levels.
 Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ccss_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pin side
    input wire logic [WIDTH-1:0] pinIn,
    // Core side
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    // First stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1_reg <= '0;
            syncOut <= '0;
        end else begin
            stage1_reg <= pinIn;
            syncOut <= stage1_reg;
        end
    end

endmodule

`default_nettype wire

/* verilog/ccss_osc_watchdog.sv */
/*
 Oscillator watchdog counter: counts free-running PLL ticks and is
 cleared by every crystal transition.
 Assumes tick and edge strobes are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccss_consts.svh"

module ccss_osc_watchdog (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic wdEnable,
    input wire logic freeRunTick,
    input wire logic crystalEdge,
    // Result
    output logic wdOverflow
);

    localparam logic [4:0] LAST_TICK = 5'(`CCSS_WD_OVERFLOW_TICKS - 1);

    logic [4:0] count_reg;

    always_ff @(posedge core_clk) begin
        if (reset || !wdEnable || crystalEdge) begin
            count_reg <= 5'h00;
        end else if (freeRunTick && count_reg != LAST_TICK) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wdOverflow <= 1'b0;
        end else begin
            wdOverflow <= wdEnable && !crystalEdge && freeRunTick &&
                count_reg == LAST_TICK;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_edge_clears: assert property (
        wdEnable && crystalEdge |=> count_reg == 5'h00 && !wdOverflow)
        else $error("watchdog count not cleared by crystal edge");

    a_overflow_count: assert property (
        $rose(wdOverflow) |-> $past(count_reg) == LAST_TICK &&
            $past(freeRunTick))
        else $error("watchdog overflow before sixteen ticks");

endmodule

`default_nettype wire

/* verilog/ccss_clock_select.sv */
/*
 CPU clock source select: strap-driven mode choice, prescaler, direct
 drive, oscillator watchdog and glitch-free switch to free-running PLL.
 Assumes a 25 MHz core_clk sampling crystal_input and straps as pins;
 the free-running PLL is modelled by a core_clk divider enable.
*/
// Contract
// - Straps sampled in reset pick the mode
// - Eight strap codes map to clock factors
// - Code 001 halves the input clock
// - Code 011 drives CPU clock from input
// - Watchdog only in direct or prescaler modes
// - Watchdog enabled after reset until disabled
// - Watchdog counts PLL ticks, crystal edges clear
// - Overflow after sixteen ticks without edge
// - Overflow selects free-run clock, raises request
// - Free-run kept until hardware reset
// - Disabled watchdog keeps oscillator, PLL off
`timescale 1ns/1ps
`default_nettype none
`include "ccss_consts.svh"

module ccss_clock_select (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins
    input wire logic crystalInput,
    input wire logic [2:0] clockModeStrapPins,
    // System config bit 4, watchdog disable
    input wire logic oscWatchdogDisable,
    // Clock outputs
    output logic cpuClk,
    output logic [2:0] clockModeStrapBits,
    output logic [3:0] pllMultTimesTwo,
    output logic pllEnable,
    // Status
    output logic freeRunSelected,
    output logic clockFailIrqRequest
);

    localparam int FR_CYC = `CCSS_FREERUN_CYCLES;
    localparam logic [7:0] FR_LAST = 8'(FR_CYC - 1);

    ccss_pkg::ccss_mode_t mode_reg;
    ccss_pkg::ccss_src_t src_reg;
    ccss_pkg::ccss_src_t src_next;
    logic [2:0] strapSync;
    logic crystalSync;
    logic crystalPrev_reg;
    logic crystalEdge;
    logic crystalRise;
    logic [7:0] frDiv_reg;
    logic freeRunTick;
    logic directMode;
    logic wdEnable;
    logic wdOverflow;
    logic pllRun;
    logic [3:0] multNext;

    ccss_sync #(.WIDTH(3)) u_strap_sync (
        .core_clk(core_clk),
        .reset(1'b0),
        .pinIn(clockModeStrapPins),
        .syncOut(strapSync)
    );

    ccss_sync #(.WIDTH(1)) u_xtal_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(crystalInput),
        .syncOut(crystalSync)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_reg <= ccss_pkg::ccss_mode_t'(strapSync);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            crystalPrev_reg <= 1'b0;
        end else begin
            crystalPrev_reg <= crystalSync;
        end
    end

    assign crystalEdge = crystalSync ^ crystalPrev_reg;
    assign crystalRise = crystalSync & ~crystalPrev_reg;

    assign directMode = mode_reg == ccss_pkg::CCSS_MODE_DIRECT ||
        mode_reg == ccss_pkg::CCSS_MODE_DIV2;

    assign wdEnable = directMode && !oscWatchdogDisable &&
        src_reg == ccss_pkg::CCSS_SRC_INPUT;

    assign pllRun = !directMode || !oscWatchdogDisable ||
        src_reg != ccss_pkg::CCSS_SRC_INPUT;

    // Free-running PLL stand-in; ticks only while the PLL runs
    always_ff @(posedge core_clk) begin
        if (reset || !pllRun) begin
            frDiv_reg <= 8'h00;
        end else if (frDiv_reg == FR_LAST) begin
            frDiv_reg <= 8'h00;
        end else begin
            frDiv_reg <= frDiv_reg + 8'h01;
        end
    end

    assign freeRunTick = pllRun && frDiv_reg == FR_LAST;

    ccss_osc_watchdog u_watchdog (
        .core_clk(core_clk),
        .reset(reset),
        .wdEnable(wdEnable),
        .freeRunTick(freeRunTick),
        .crystalEdge(crystalEdge),
        .wdOverflow(wdOverflow)
    );

    always_comb begin
        src_next = src_reg;
        case (src_reg)
            ccss_pkg::CCSS_SRC_INPUT: begin
                if (wdOverflow) begin
                    src_next = ccss_pkg::CCSS_SRC_ARMING;
                end
            end
            ccss_pkg::CCSS_SRC_ARMING: begin
                if (freeRunTick) begin
                    src_next = ccss_pkg::CCSS_SRC_FREERUN;
                end
            end
            ccss_pkg::CCSS_SRC_FREERUN: begin
                src_next = ccss_pkg::CCSS_SRC_FREERUN;
            end
            default: begin
                src_next = ccss_pkg::CCSS_SRC_FREERUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_reg <= ccss_pkg::CCSS_SRC_INPUT;
        end else begin
            src_reg <= src_next;
        end
    end

    // CPU clock; the level is frozen while arming so the first free-run
    // half period is a full tick, never a sliver of the old source
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cpuClk <= 1'b0;
        end else begin
            case (src_reg)
                ccss_pkg::CCSS_SRC_INPUT: begin
                    if (mode_reg == ccss_pkg::CCSS_MODE_DIRECT) begin
                        cpuClk <= crystalSync;
                    end else if (mode_reg == ccss_pkg::CCSS_MODE_DIV2) begin
                        if (crystalRise) begin
                            cpuClk <= ~cpuClk;
                        end
                    end else if (freeRunTick) begin
                        cpuClk <= ~cpuClk;
                    end
                end
                ccss_pkg::CCSS_SRC_ARMING: begin
                    cpuClk <= cpuClk;
                end
                default: begin
                    if (freeRunTick) begin
                        cpuClk <= ~cpuClk;
                    end
                end
            endcase
        end
    end

    always_comb begin
        case (mode_reg)
            ccss_pkg::CCSS_MODE_X4: multNext = 4'h8;
            ccss_pkg::CCSS_MODE_X3: multNext = 4'h6;
            ccss_pkg::CCSS_MODE_X2: multNext = 4'h4;
            ccss_pkg::CCSS_MODE_X5: multNext = 4'hA;
            ccss_pkg::CCSS_MODE_DIRECT: multNext = 4'h2;
            ccss_pkg::CCSS_MODE_X1P5: multNext = 4'h3;
            ccss_pkg::CCSS_MODE_DIV2: multNext = 4'h1;
            ccss_pkg::CCSS_MODE_X2P5: multNext = 4'h5;
            default: multNext = 4'h8;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clockModeStrapBits <= `CCSS_STRAP_DEFAULT;
            pllMultTimesTwo <= 4'h0;
            pllEnable <= 1'b0;
        end else begin
            clockModeStrapBits <= mode_reg;
            pllMultTimesTwo <= multNext;
            pllEnable <= pllRun;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clockFailIrqRequest <= 1'b0;
            freeRunSelected <= 1'b0;
        end else begin
            clockFailIrqRequest <= wdOverflow &&
                src_reg == ccss_pkg::CCSS_SRC_INPUT;
            freeRunSelected <= src_next != ccss_pkg::CCSS_SRC_INPUT;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_overflow;
        wdOverflow && src_reg == ccss_pkg::CCSS_SRC_INPUT;
    endsequence

    sequence s_switched;
        src_reg == ccss_pkg::CCSS_SRC_ARMING && clockFailIrqRequest;
    endsequence

    a_mode_held: assert property (
        $past(!reset) |-> $stable(mode_reg))
        else $error("clock mode changed outside reset");

    a_prescale_toggle: assert property (
        src_reg == ccss_pkg::CCSS_SRC_INPUT &&
        mode_reg == ccss_pkg::CCSS_MODE_DIV2 && crystalRise
        |=> cpuClk != $past(cpuClk))
        else $error("prescaler missed a crystal period");

    a_direct_follow: assert property (
        src_reg == ccss_pkg::CCSS_SRC_INPUT &&
        mode_reg == ccss_pkg::CCSS_MODE_DIRECT
        |=> cpuClk == $past(crystalSync))
        else $error("direct clock does not follow input");

    a_wd_scope: assert property (
        !directMode |-> !wdEnable ##1 !clockFailIrqRequest)
        else $error("watchdog active outside direct modes");

    a_wd_on: assert property (
        directMode && !oscWatchdogDisable |=> pllEnable)
        else $error("watchdog PLL not running while enabled");

    a_fail_switch: assert property (
        s_overflow |=> s_switched ##[1:8]
            src_reg == ccss_pkg::CCSS_SRC_FREERUN && freeRunSelected)
        else $error("overflow did not switch to free-run clock");

    a_no_return: assert property (
        src_reg != ccss_pkg::CCSS_SRC_INPUT
        |=> src_reg != ccss_pkg::CCSS_SRC_INPUT && freeRunSelected)
        else $error("clock source returned to input");

    a_pll_off: assert property (
        directMode && oscWatchdogDisable &&
        src_reg == ccss_pkg::CCSS_SRC_INPUT |=> !pllEnable)
        else $error("PLL running with watchdog disabled");

    a_glitch_free: assert property (
        src_reg == ccss_pkg::CCSS_SRC_ARMING |=> $stable(cpuClk))
        else $error("CPU clock edge during switchover");

    a_bits_track: assert property (
        $past(!reset) |-> clockModeStrapBits == mode_reg)
        else $error("strap bits differ from latched mode");

    a_default_factor: assert property (
        mode_reg == ccss_pkg::CCSS_MODE_X4 |=> pllMultTimesTwo == 4'h8)
        else $error("default strap code gives wrong factor");

    // One pulse per failure, so an edge-counting handler sees one event
    a_irq_single: assert property (
        clockFailIrqRequest |=> !clockFailIrqRequest)
        else $error("clock fail request longer than one cycle");

    a_freerun_rate: assert property (
        src_reg == ccss_pkg::CCSS_SRC_FREERUN && freeRunTick
        |=> cpuClk != $past(cpuClk))
        else $error("free-run clock missed a tick");

endmodule

`default_nettype wire

/* tb/ccss_xtal_model.sv */
/*
 External clock source model that drives the crystal pin.
 Assumes it is stepped on core_clk; a stopped source parks the pin.
*/
`timescale 1ns/1ps
`default_nettype none

module ccss_xtal_model (
    // Clock
    input wire logic core_clk,
    // Control
    input wire logic run,
    input wire logic [3:0] highCycles,
    input wire logic [3:0] lowCycles,
    // Pin
    output logic crystal
);
    logic [3:0] cnt_reg;

    initial begin
        crystal = 1'b0;
        cnt_reg = 4'h0;
    end

    // transitions or silence
    // A failed source keeps its last level, just as a dead oscillator would
    always @(posedge core_clk) begin
        if (run) begin
            if (cnt_reg + 4'h1 >= (crystal ? highCycles : lowCycles)) begin
                crystal <= ~crystal;
                cnt_reg <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
 Self-checking bench for the CPU clock source select block.
 Assumes a 25 MHz core_clk and the crystal model as the clock source.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strapPins = 3'h7;
    logic wdDisable = 1'b0;
    logic xtalRun = 1'b1;
    wire logic crystal;
    wire logic cpuClk;
    wire logic [2:0] strapBits;
    wire logic [3:0] multX2;
    wire logic pllEnable;
    wire logic freeRun;
    wire logic irq;
    int failCount = 0;
    int checks = 0;
    int cyc = 0;
    int total = 0;
    int runLen = 0;
    int minRun = 999;
    int maxRun = 0;
    int irqCount = 0;
    int irqAt = 0;
    bit seen = 0;
    logic lastClk = 1'b0;
    logic [3:0] multTable [8] = '{4'h5, 4'h1, 4'h3, 4'h2,
                                  4'hA, 4'h4, 4'h6, 4'h8};

    always #20 core_clk = ~core_clk;

    ccss_xtal_model xtal (
        .core_clk(core_clk),
        .run(xtalRun),
        .highCycles(4'h4),
        .lowCycles(4'h3),
        .crystal(crystal)
    );

    ccss_clock_select uut (
        .core_clk(core_clk),
        .reset(reset),
        .crystalInput(crystal),
        .clockModeStrapPins(strapPins),
        .oscWatchdogDisable(wdDisable),
        .cpuClk(cpuClk),
        .clockModeStrapBits(strapBits),
        .pllMultTimesTwo(multX2),
        .pllEnable(pllEnable),
        .freeRunSelected(freeRun),
        .clockFailIrqRequest(irq)
    );

    // Run lengths of cpuClk and request pulses; first partial run ignored
    always @(posedge core_clk) begin
        #1;
        cyc++;
        total++;
        if (irq === 1'b1) begin
            irqCount++;
            if (irqCount == 1) irqAt = cyc;
        end
        if (cpuClk !== lastClk) begin
            if (seen && runLen < minRun) minRun = runLen;
            if (seen && runLen > maxRun) maxRun = runLen;
            seen = 1;
            runLen = 0;
            lastClk = cpuClk;
        end
        runLen++;
        if (total == 5000) begin
            failCount++;
            conclude();
        end
    end

    task automatic conclude();
        if (failCount == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_int(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            failCount++;
            $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic clear_mon();
        seen = 0;
        minRun = 999;
        maxRun = 0;
        irqCount = 0;
        irqAt = 0;
        cyc = 0;
    endtask

    // Reset held four edges so the straps clear the synchroniser
    task automatic do_reset(input logic [2:0] m, input logic d);
        @(posedge core_clk);
        strapPins <= m;
        wdDisable <= d;
        xtalRun <= 1'b1;
        reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_straps();
        for (int m = 0; m < 8; m++) begin
            do_reset(m[2:0], 1'b0);
            chk({1'b0, strapBits}, {1'b0, m[2:0]});
            chk(multX2, multTable[m]);
            chk({3'h0, pllEnable}, 4'h1);
            @(posedge core_clk);
            strapPins <= ~m[2:0];
            repeat (5) @(posedge core_clk);
            #1;
            chk({1'b0, strapBits}, {1'b0, m[2:0]});
        end
        do_reset(3'h3, 1'b1);
        chk({3'h0, pllEnable}, 4'h0);
        do_reset(3'h1, 1'b1);
        chk({3'h0, pllEnable}, 4'h0);
    endtask

    // Crystal high 4 cycles, low 3: direct keeps duty, prescaler doubles
    task automatic t_paths();
        do_reset(3'h1, 1'b0);
        repeat (12) @(posedge core_clk);
        clear_mon();
        repeat (60) @(posedge core_clk);
        chk_int(minRun, 7, 7);
        chk_int(maxRun, 7, 7);
        do_reset(3'h3, 1'b0);
        repeat (12) @(posedge core_clk);
        clear_mon();
        repeat (60) @(posedge core_clk);
        chk_int(minRun, 3, 3);
        chk_int(maxRun, 4, 4);
        chk_int(irqCount, 0, 0);
    endtask

    task automatic t_watchdog(input logic [2:0] m);
        do_reset(m, 1'b0);
        chk({3'h0, freeRun}, 4'h0);
        repeat (20) @(posedge core_clk);
        xtalRun <= 1'b0;
        clear_mon();
        repeat (70) @(posedge core_clk);
        #1;
        chk_int(irqCount, 1, 1);
        chk_int(irqAt, 33, 40);
        chk_int(minRun, 2, 999);
        chk({3'h0, freeRun}, 4'h1);
        clear_mon();
        xtalRun <= 1'b1;
        repeat (60) @(posedge core_clk);
        chk_int(minRun, 2, 2);
        chk_int(maxRun, 2, 2);
        chk_int(irqCount, 0, 0);
        chk({3'h0, freeRun}, 4'h1);
    endtask

    // A dead source must go unnoticed when the watchdog is off or unused
    task automatic t_no_watchdog(input logic [2:0] m, input logic d);
        do_reset(m, d);
        repeat (10) @(posedge core_clk);
        xtalRun <= 1'b0;
        clear_mon();
        repeat (100) @(posedge core_clk);
        #1;
        chk_int(irqCount, 0, 0);
        chk({3'h0, freeRun}, 4'h0);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        t_straps();
        t_paths();
        t_watchdog(3'h3);
        t_watchdog(3'h1);
        t_no_watchdog(3'h3, 1'b1);
        t_no_watchdog(3'h7, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire
